// ==== core/sbtc_pkg.sv ====
// package: register map, encodings and timing constants of the sweep/burst trigger controller
package sbtc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MARK_PULSE_NS = 1100;
  localparam int unsigned MARK_PULSE_CYC = (MARK_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned FSK_MAX_HZ = 1000000;
  localparam int unsigned FSK_MIN_CYC = CLK_HZ / FSK_MAX_HZ;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_CMD    = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_FUNC_LSB  = 2;
  localparam int CTRL_SLOPE     = 4;
  localparam int CTRL_OUT_EN    = 5;
  localparam int CTRL_OUT_POL   = 6;
  localparam int CTRL_GATED     = 7;
  localparam int CTRL_FSK_EXT   = 8;
  localparam int CTRL_NOISE     = 9;
  localparam int CTRL_REMOTE    = 10;
  localparam int CMD_BUS_TRIG   = 0;
  localparam int CMD_APPLY      = 1;
  localparam int CMD_RESET      = 2;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0020;
  localparam logic [31:0] PERIOD_RESET = 32'h0003_0D40;
  localparam logic [31:0] PERIOD_MIN   = 32'h0000_0002;

  typedef enum logic [1:0] {SBTC_SRC_INT, SBTC_SRC_EXT, SBTC_SRC_MAN, SBTC_SRC_BUS} sbtc_src_t;
  typedef enum logic [1:0] {SBTC_FN_OTHER, SBTC_FN_SWEEP, SBTC_FN_BURST, SBTC_FN_FSK} sbtc_func_t;
endpackage

// ==== core/sbtc_top.sv ====
// sweep/burst trigger controller: source select, start pulses, trigger marker, gate and fsk
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
module sbtc_top
  import sbtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trig_in,
  input  wire logic        manual_key,
  input  wire logic        cycle_busy,
  input  wire logic        cycle_end,
  output logic             start_pulse,
  output logic             run_gate,
  output logic             stop_now,
  output logic             hop_select,
  output logic             key_lamp,
  output logic             trig_out,
  output logic             trig_out_oe
);
  import sbtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [31:0] period_q;
  logic        rd_pend_q;
  logic        bus_trig_q;
  logic        apply_q;
  logic        soft_rst_q;
  logic        wr_ok;
  sbtc_src_t   src;
  sbtc_func_t  func;
  logic        trig_active;
  logic        gated_burst_mode;
  logic        fsk_external_source;
  logic        noise_wave;
  logic        remote_mode;
  logic        burst_run_q;
  logic        waiting;

  assign src                 = sbtc_src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
  assign func                = sbtc_func_t'(ctrl_q[CTRL_FUNC_LSB +: 2]);
  assign gated_burst_mode    = ctrl_q[CTRL_GATED];
  assign fsk_external_source = ctrl_q[CTRL_FSK_EXT];
  assign noise_wave          = ctrl_q[CTRL_NOISE];
  assign remote_mode         = ctrl_q[CTRL_REMOTE];
  assign trig_active         = (func == SBTC_FN_SWEEP) || (func == SBTC_FN_BURST && !gated_burst_mode);

  // writes finish in the cycle they appear; reads take one wait cycle
  assign wr_ok           = avs_write && (avs_byteenable == 4'hF);
  assign avs_waitrequest = avs_read && !rd_pend_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_pend_q) begin
      unique case (avs_address)
        ADDR_CTRL:   avs_readdata <= ctrl_q;
        ADDR_PERIOD: avs_readdata <= period_q;
        ADDR_STATUS: avs_readdata <= {29'h0000_0000, waiting, burst_run_q, trig_out};
        default:     avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // partial-width writes are ignored: every field must land together
  always_ff @(posedge clk) begin
    if (reset || soft_rst_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (apply_q) begin
      ctrl_q[CTRL_SRC_LSB +: 2] <= SBTC_SRC_INT;
    end else if (wr_ok && avs_address == ADDR_CTRL) begin
      ctrl_q <= {21'h00_0000, avs_writedata[10:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      period_q <= PERIOD_RESET;
    end else if (wr_ok && avs_address == ADDR_PERIOD) begin
      period_q <= (avs_writedata < PERIOD_MIN) ? PERIOD_MIN : avs_writedata;
    end
  end

  // command bits act one cycle after the write; remote reset outranks apply
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_trig_q <= 1'b0;
      apply_q    <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      bus_trig_q <= wr_ok && avs_address == ADDR_CMD && avs_writedata[CMD_BUS_TRIG];
      apply_q    <= wr_ok && avs_address == ADDR_CMD && avs_writedata[CMD_APPLY];
      soft_rst_q <= wr_ok && avs_address == ADDR_CMD && avs_writedata[CMD_RESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser; first stage feeds only the second
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic ext_edge;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= trig_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign ext_edge = ctrl_q[CTRL_SLOPE] ? (sync3_q && !sync2_q) : (!sync3_q && sync2_q);

  logic key_q;
  logic key_press;
  always_ff @(posedge clk) begin
    if (reset) begin
      key_q <= 1'b0;
    end else begin
      key_q <= manual_key;
    end
  end
  assign key_press = manual_key && !key_q && !remote_mode;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] per_cnt_q;
  logic        int_tick;
  logic        start_d;

  // a cleared count fires at once: the first start follows selection by one cycle
  assign int_tick = (per_cnt_q == 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (reset || src != SBTC_SRC_INT || !trig_active) begin
      per_cnt_q <= 32'h0000_0000;
    end else if (int_tick) begin
      per_cnt_q <= period_q - 32'h0000_0001;
    end else begin
      per_cnt_q <= per_cnt_q - 32'h0000_0001;
    end
  end

  // events of unselected sources are dropped here, never queued
  always_comb begin
    start_d = 1'b0;
    if (trig_active) begin
      unique case (src)
        SBTC_SRC_INT: start_d = int_tick;
        SBTC_SRC_EXT: start_d = ext_edge && !burst_run_q && !cycle_busy;
        SBTC_SRC_MAN: start_d = key_press && !burst_run_q;
        SBTC_SRC_BUS: start_d = bus_trig_q && !burst_run_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= start_d;
    end
  end

  // burst_run holds from start until the engine reports the burst done
  always_ff @(posedge clk) begin
    if (reset || !trig_active) begin
      burst_run_q <= 1'b0;
    end else if (start_pulse) begin
      burst_run_q <= 1'b1;
    end else if (cycle_end) begin
      burst_run_q <= 1'b0;
    end
  end

  assign waiting  = trig_active && !burst_run_q && (src == SBTC_SRC_MAN || src == SBTC_SRC_BUS);
  assign key_lamp = waiting;

  ////////////////////////////////////////////////////////////////////////////
  // gated burst and fsk both read the synchronised level
  logic gate_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= 1'b0;
    end else if (!(func == SBTC_FN_BURST && gated_burst_mode)) begin
      gate_q <= 1'b0;
    end else if (sync2_q) begin
      gate_q <= 1'b1;
    end else if (noise_wave || cycle_end) begin
      gate_q <= 1'b0;
    end
  end
  assign run_gate = gate_q;
  assign stop_now = gate_q && !sync2_q && noise_wave;

  // registered so the hop line never glitches while the source settles
  always_ff @(posedge clk) begin
    if (reset) begin
      hop_select <= 1'b0;
    end else begin
      hop_select <= (func == SBTC_FN_FSK) && fsk_external_source && sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] mark_cnt_q;
  logic        mark_q;
  logic [31:0] half_period;
  assign half_period = {1'b0, period_q[31:1]};
  // counter starts at one so the high time equals the compare value exactly

  always_ff @(posedge clk) begin
    if (reset || !trig_active) begin
      mark_q     <= 1'b0;
      mark_cnt_q <= 32'h0000_0000;
    end else if (start_pulse) begin
      mark_q     <= 1'b1;
      mark_cnt_q <= 32'h0000_0001;
    end else if (mark_q) begin
      mark_cnt_q <= mark_cnt_q + 32'h0000_0001;
      if (src == SBTC_SRC_INT && mark_cnt_q >= half_period) begin
        mark_q <= 1'b0;
      end else if (src != SBTC_SRC_INT && mark_cnt_q >= MARK_PULSE_CYC) begin
        mark_q <= 1'b0;
      end
    end
  end

  assign trig_out_oe = ctrl_q[CTRL_OUT_EN] && trig_active && src != SBTC_SRC_EXT;
  assign trig_out    = trig_out_oe && (mark_q ^ ctrl_q[CTRL_OUT_POL]);

  ////////////////////////////////////////////////////////////////////////////
  // checks watch internal nets; covers mark the main source paths
  property p_one_source;
    @(posedge clk) disable iff (reset) start_d |-> trig_active;
  endproperty
  a_one_source: assert property (p_one_source) else $error("start outside sweep or burst");

  property p_ext_edge;
    @(posedge clk) disable iff (reset)
      (src == SBTC_SRC_EXT && trig_active && $rose(sync2_q) && !ctrl_q[CTRL_SLOPE] && !burst_run_q && !cycle_busy)
      |-> start_d ##1 start_pulse;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("rising edge did not start");

  property p_ignore_busy;
    @(posedge clk) disable iff (reset) (src == SBTC_SRC_EXT && burst_run_q) |-> !start_d;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("edge taken during burst");

  property p_remote_key;
    @(posedge clk) disable iff (reset) (src == SBTC_SRC_MAN && remote_mode) |-> !start_d;
  endproperty
  a_remote_key: assert property (p_remote_key) else $error("key honoured in remote");

  property p_bus_start;
    @(posedge clk) disable iff (reset)
      (bus_trig_q && src == SBTC_SRC_BUS && trig_active && !burst_run_q) |=> start_pulse;
  endproperty
  a_bus_start: assert property (p_bus_start) else $error("bus command lost");

  property p_apply;
    @(posedge clk) disable iff (reset) apply_q && !soft_rst_q |=> src == SBTC_SRC_INT;
  endproperty
  a_apply: assert property (p_apply) else $error("configure did not force immediate");

  property p_ext_oe;
    @(posedge clk) disable iff (reset) src == SBTC_SRC_EXT |-> !trig_out_oe;
  endproperty
  a_ext_oe: assert property (p_ext_oe) else $error("marker driven with external source");

  property p_bus_width;
    @(posedge clk) disable iff (reset)
      (start_pulse && src == SBTC_SRC_BUS && trig_active) |=> mark_q [*8];
  endproperty
  a_bus_width: assert property (p_bus_width) else $error("bus marker too short");

  property p_lamp;
    @(posedge clk) disable iff (reset) (src == SBTC_SRC_MAN && trig_active && !burst_run_q) |-> key_lamp;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp dark while waiting");

  property p_reset_src;
    @(posedge clk) reset |=> src == SBTC_SRC_INT;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset left non-internal source");

  property p_noise_stop;
    @(posedge clk) disable iff (reset)
      (run_gate && !sync2_q && noise_wave && func == SBTC_FN_BURST) |-> stop_now ##1 !run_gate;
  endproperty
  a_noise_stop: assert property (p_noise_stop) else $error("noise output not stopped");

  property p_hop;
    @(posedge clk) disable iff (reset)
      (func == SBTC_FN_FSK && fsk_external_source) |=> hop_select == $past(sync2_q);
  endproperty
  a_hop: assert property (p_hop) else $error("hop select not following input level");

  property p_gate_hold;
    @(posedge clk) disable iff (reset)
      (run_gate && !sync2_q && !noise_wave && !cycle_end && func == SBTC_FN_BURST && gated_burst_mode)
      |=> run_gate;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate dropped before cycle end");

  c_int: cover property (@(posedge clk) src == SBTC_SRC_INT && start_pulse);
  c_ext: cover property (@(posedge clk) src == SBTC_SRC_EXT && start_pulse);
  c_bus: cover property (@(posedge clk) src == SBTC_SRC_BUS && start_pulse);
  c_gate: cover property (@(posedge clk) $fell(run_gate));
  c_man: cover property (@(posedge clk) src == SBTC_SRC_MAN && start_pulse);
endmodule

// ==== sim/sbtc_partner.sv ====
// partner model: rate-limited external trigger source and a sweep/burst engine
module sbtc_partner (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic lvl_req,
  input  wire logic start_pulse,
  input  wire logic run_gate,
  output logic      trig_in,
  output logic      cycle_busy,
  output logic      cycle_end
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_q;
  int busy_q;
  ////////////////////////////////////////////////////////////////////////////////
  // a requested toggle waits until 20 clocks have passed since the last one
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_in <= 1'b0;
      gap_q <= 0;
    end else if (gap_q != 0) begin
      gap_q <= gap_q - 1;
    end else if (lvl_req != trig_in) begin
      trig_in <= lvl_req;
      gap_q <= 19;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bursts last 60 clocks; gated cycles 30, long enough to tell noise stop apart
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 0;
      cycle_end <= 1'b0;
    end else begin
      cycle_end <= (busy_q == 1);
      if (busy_q != 0) busy_q <= busy_q - 1;
      else if (start_pulse) busy_q <= 60;
      else if (run_gate) busy_q <= 30;
    end
  end
  assign cycle_busy = (busy_q != 0);
endmodule

// ==== sim/sweep_burst_trigger_control_tb.sv ====
// self-checking bench of the sweep/burst trigger controller
module sweep_burst_trigger_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbtc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        manual_key = 1'b0;
  logic        lvl_req = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, trig_in, cycle_busy, cycle_end, start_pulse;
  logic        run_gate, stop_now, hop_select, key_lamp, trig_out, trig_out_oe;
  logic [31:0] exp_q[$];
  int          failures = 0;
  int          n_compared = 0;
  int          n_start = 0;
  int          n_mark = 0;
  int          n_stop = 0;
  int          seed = 62;
  int          p;
  int          c0;
  int          m0;

  always #25 clk = ~clk;
  always @(posedge clk) if (start_pulse === 1'b1) n_start++;
  always @(posedge clk) if (trig_out === 1'b1) n_mark++;
  always @(posedge clk) if (stop_now === 1'b1) n_stop++;
  always @(posedge clk) if (avs_read && !avs_waitrequest) chk(avs_readdata, exp_q.pop_front());
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("wrong value at %0t: run timeout", $time);
    final_report();
  end

  sbtc_top DUT (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
    .manual_key(manual_key), .cycle_busy(cycle_busy), .cycle_end(cycle_end),
    .start_pulse(start_pulse), .run_gate(run_gate), .stop_now(stop_now), .hop_select(hop_select),
    .key_lamp(key_lamp), .trig_out(trig_out), .trig_out_oe(trig_out_oe));
  sbtc_partner far_side (.clk(clk), .reset(reset), .lvl_req(lvl_req), .start_pulse(start_pulse),
    .run_gate(run_gate), .trig_in(trig_in), .cycle_busy(cycle_busy), .cycle_end(cycle_end));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request held until a rising edge samples waitrequest low; released only after that edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest && k < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest) begin
      failures++;
      $display("wrong value at %0t: bus timeout", $time);
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hF);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0, 4'hF);
  endtask
  // events counted over exactly n rising edges, sampled between edges
  task automatic gap(input int n);
    @(negedge clk);
    c0 = n_start;
    m0 = n_mark;
    repeat (n) @(posedge clk);
    @(negedge clk);
    c0 = n_start - c0;
    m0 = n_mark - m0;
    @(posedge clk);
  endtask
  task automatic lvl(input logic v, input int n);
    lvl_req <= v;
    cyc(n);
  endtask
  task automatic press();
    manual_key <= 1'b1;
    cyc(5);
    manual_key <= 1'b0;
    cyc(70);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_PERIOD, PERIOD_RESET);
    rd(4'h1, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0, 4'h3);
    rd(ADDR_CTRL, CTRL_RESET);
    $display("test reset done");
    p = 20 + 2 * ($random(seed) & 7);
    wr(ADDR_PERIOD, 32'(p));
    wr(ADDR_CTRL, 32'h28);
    gap(2 * p);
    gap(4 * p);
    chk(32'(c0), 32'h4);
    chk(32'(m0), 32'(2 * p));
    wr(ADDR_CTRL, 32'h20);
    gap(4 * p);
    chk(32'(c0), 32'h0);
    $display("test internal done");
    wr(ADDR_CTRL, 32'h29);
    cyc(70);
    chk1(trig_out_oe, 1'b0);
    c0 = n_start;
    lvl(1'b1, 21);
    lvl(1'b0, 21);
    lvl(1'b1, 80);
    chk(32'(n_start - c0), 32'h1);
    lvl(1'b0, 21);
    lvl(1'b1, 80);
    chk(32'(n_start - c0), 32'h2);
    wr(ADDR_CTRL, 32'h39);
    lvl(1'b0, 80);
    chk(32'(n_start - c0), 32'h3);
    $display("test external done");
    wr(ADDR_CTRL, 32'h2B);
    cyc(4);
    chk1(key_lamp, 1'b1);
    c0 = n_start;
    m0 = n_mark;
    wr(ADDR_CMD, 32'h1);
    cyc(70);
    chk(32'(n_start - c0), 32'h1);
    chk(32'(n_mark - m0), MARK_PULSE_CYC);
    press();
    chk(32'(n_start - c0), 32'h1);
    wr(ADDR_CTRL, 32'h6B);
    cyc(2);
    chk1(trig_out, 1'b1);
    $display("test bus done");
    wr(ADDR_CTRL, 32'h2A);
    cyc(4);
    chk1(key_lamp, 1'b1);
    press();
    chk(32'(n_start - c0), 32'h2);
    wr(ADDR_CTRL, 32'h42A);
    press();
    chk(32'(n_start - c0), 32'h2);
    wr(ADDR_CTRL, 32'h2B);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_CTRL, 32'h28);
    wr(ADDR_CTRL, 32'h7A9);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_CTRL, CTRL_RESET);
    $display("test manual done");
    wr(ADDR_CTRL, 32'h12C);
    lvl(1'b1, 25);
    chk1(hop_select, 1'b1);
    lvl(1'b0, 25);
    chk1(hop_select, 1'b0);
    wr(ADDR_CTRL, 32'hA8);
    lvl(1'b1, 25);
    chk1(run_gate, 1'b1);
    lvl(1'b0, 70);
    chk1(run_gate, 1'b0);
    chk(32'(n_stop), 32'h0);
    wr(ADDR_CTRL, 32'h2A8);
    lvl(1'b1, 25);
    lvl(1'b0, 6);
    chk1(run_gate, 1'b0);
    chk(32'(n_stop), 32'h1);
    $display("test gate done");
    final_report();
  end
endmodule
